/* pocr_pkg.sv */
// Constants for the output, loop bandwidth and oscillator calibration register bank
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pocr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FREQ_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_DIFF_OUTPUT_STANDARD   = 8'h3a;
  localparam logic [7:0] OFF_LOOP_BANDWIDTH_CONTROL = 8'h3b;
  localparam logic [7:0] OFF_OSC_CALIBRATION_LOW    = 8'h3c;

  // Reset values
  localparam logic [7:0] RST_DIFF_OUTPUT_STANDARD   = 8'hc2;
  localparam logic [7:0] RST_LOOP_BANDWIDTH_CONTROL = 8'h98;
  localparam logic [7:0] RST_OSC_CALIBRATION_LOW    = 8'h99;

  // Implemented bits of each register
  localparam logic [7:0] MASK_DIFF_OUTPUT_STANDARD   = 8'h03;
  localparam logic [7:0] MASK_LOOP_BANDWIDTH_CONTROL = 8'h88;
  localparam logic [7:0] MASK_OSC_CALIBRATION_LOW    = 8'hff;

  // Field positions
  localparam int unsigned BIT_BANDWIDTH_AUTO_CHOOSE   = 7;
  localparam int unsigned BIT_LOOP_INTEGRATOR_CLAMP   = 3;
  localparam int unsigned LSB_DIFF_OUT_STANDARD_SEL   = 0;
  localparam int unsigned MSB_DIFF_OUT_STANDARD_SEL   = 1;

  // Output standard encodings
  localparam logic [1:0] STD_DISABLED = 2'h0;
  localparam logic [1:0] STD_PECL     = 2'h1;
  localparam logic [1:0] STD_LVDS     = 2'h2;

endpackage : pocr_pkg

/* pocr_regs.sv */
// Register bank for differential output standard, loop bandwidth and oscillator calibration
`timescale 1ns/100ps

module pocr_regs
  import pocr_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic [DATA_W-1:0] osc_calibration_high_in,
  input  wire logic              loop_locked_in,
  input  wire logic              at_min_limit_in,
  input  wire logic              at_max_limit_in,
  input  wire logic [FREQ_W-1:0] loop_freq_in,
  output logic                   pecl_enable_out,
  output logic                   lvds_enable_out,
  output logic                   diff_driver_enable_out,
  output logic                   use_acquisition_bw_out,
  output logic                   integrator_freeze_out,
  output logic      [FREQ_W-1:0] reported_freq_out,
  output logic      [15:0]       osc_calibration_word_out
);

  //----------------------------------------------------------------------------
  // Register storage
  //----------------------------------------------------------------------------
  logic [DATA_W-1:0] diff_output_standard;
  logic [DATA_W-1:0] loop_bandwidth_control;
  logic [DATA_W-1:0] osc_calibration_low;
  logic [DATA_W-1:0] next_diff_output_standard;
  logic [DATA_W-1:0] next_loop_bandwidth_control;
  logic [DATA_W-1:0] next_osc_calibration_low;
  logic [DATA_W-1:0] next_rd_data;

  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] mask,
    input logic              hit,
    input logic [DATA_W-1:0] data
  );
    merge_write = hit ? (data & mask) : cur;
  endfunction : merge_write

  always_comb
  begin
    next_diff_output_standard   = merge_write(diff_output_standard, MASK_DIFF_OUTPUT_STANDARD,
      wr_en_in && (addr_in == OFF_DIFF_OUTPUT_STANDARD), wr_data_in);
    next_loop_bandwidth_control = merge_write(loop_bandwidth_control,
      MASK_LOOP_BANDWIDTH_CONTROL,
      wr_en_in && (addr_in == OFF_LOOP_BANDWIDTH_CONTROL), wr_data_in);
    next_osc_calibration_low    = merge_write(osc_calibration_low, MASK_OSC_CALIBRATION_LOW,
      wr_en_in && (addr_in == OFF_OSC_CALIBRATION_LOW), wr_data_in);
    unique case (addr_in)
      OFF_DIFF_OUTPUT_STANDARD:   next_rd_data = diff_output_standard;
      OFF_LOOP_BANDWIDTH_CONTROL: next_rd_data = loop_bandwidth_control;
      OFF_OSC_CALIBRATION_LOW:    next_rd_data = osc_calibration_low;
      default:                    next_rd_data = 8'h00;
    endcase
  end

  // Reset values carry unused ones in the printed defaults; masked so they read zero
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      diff_output_standard   <= RST_DIFF_OUTPUT_STANDARD & MASK_DIFF_OUTPUT_STANDARD;
      loop_bandwidth_control <= RST_LOOP_BANDWIDTH_CONTROL & MASK_LOOP_BANDWIDTH_CONTROL;
      osc_calibration_low    <= RST_OSC_CALIBRATION_LOW;
      rd_data_out            <= 8'h00;
    end
    else
    begin
      diff_output_standard   <= next_diff_output_standard;
      loop_bandwidth_control <= next_loop_bandwidth_control;
      osc_calibration_low    <= next_osc_calibration_low;
      rd_data_out            <= next_rd_data;
    end
  end

  //----------------------------------------------------------------------------
  // Controls derived from the registers
  //----------------------------------------------------------------------------
  logic [1:0]        diff_out_standard_sel;
  logic              bandwidth_auto_choose;
  logic              loop_integrator_clamp;
  logic              next_pecl_enable;
  logic              next_lvds_enable;
  logic              next_use_acq_bw;
  logic              next_freeze;
  logic [FREQ_W-1:0] next_reported_freq;
  logic [15:0]       next_cal_word;

  assign diff_out_standard_sel =
    diff_output_standard[MSB_DIFF_OUT_STANDARD_SEL:LSB_DIFF_OUT_STANDARD_SEL];
  assign bandwidth_auto_choose = loop_bandwidth_control[BIT_BANDWIDTH_AUTO_CHOOSE];
  assign loop_integrator_clamp = loop_bandwidth_control[BIT_LOOP_INTEGRATOR_CLAMP];

  always_comb
  begin
    // Code 11 is undefined; it keeps the driver off rather than guess a level
    next_pecl_enable   = (diff_out_standard_sel == STD_PECL);
    next_lvds_enable   = (diff_out_standard_sel == STD_LVDS);
    next_use_acq_bw    = bandwidth_auto_choose && !loop_locked_in;
    next_freeze        = loop_integrator_clamp && (at_min_limit_in || at_max_limit_in);
    next_reported_freq = next_freeze ? reported_freq_out : loop_freq_in;
    next_cal_word      = {osc_calibration_high_in, osc_calibration_low};
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      pecl_enable_out          <= 1'b0;
      lvds_enable_out          <= 1'b0;
      diff_driver_enable_out   <= 1'b0;
      use_acquisition_bw_out   <= 1'b0;
      integrator_freeze_out    <= 1'b0;
      reported_freq_out        <= 16'h0000;
      osc_calibration_word_out <= 16'h0000;
    end
    else
    begin
      pecl_enable_out          <= next_pecl_enable;
      lvds_enable_out          <= next_lvds_enable;
      diff_driver_enable_out   <= next_pecl_enable || next_lvds_enable;
      use_acquisition_bw_out   <= next_use_acq_bw;
      integrator_freeze_out    <= next_freeze;
      reported_freq_out        <= next_reported_freq;
      osc_calibration_word_out <= next_cal_word;
    end
  end

endmodule : pocr_regs

/* pocr_regs_props.sv */
// Port checker and bind for the output, loop and calibration register bank
`timescale 1ns/100ps
//----------
// Checker
//----------
module pocr_chk
  import pocr_pkg::*;
(
  input wire logic ref_clk_in, srst_in, wr_en_in, loop_locked_in, at_min_limit_in,
  input wire logic at_max_limit_in, pecl_enable_out, lvds_enable_out,
  input wire logic diff_driver_enable_out, use_acquisition_bw_out, integrator_freeze_out,
  input wire logic [7:0] addr_in, wr_data_in, rd_data_out, osc_calibration_high_in,
  input wire logic [15:0] loop_freq_in, reported_freq_out, osc_calibration_word_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  // Xor also catches both standards on at once
  chk_drv_enable: assert property (diff_driver_enable_out == (pecl_enable_out ^ lvds_enable_out))
    else $error("driver enable");
  chk_acq_locked: assert property (loop_locked_in |=> !use_acquisition_bw_out)
    else $error("acquisition bw while locked");
  chk_freeze_free: assert property (!at_min_limit_in && !at_max_limit_in |=> !integrator_freeze_out)
    else $error("freeze off limits");
  chk_freq_hold: assert property (integrator_freeze_out && $past(integrator_freeze_out)
    |-> $stable(reported_freq_out))
    else $error("reported freq moved");
  chk_cal_low: assert property (wr_en_in && addr_in == 8'h3c ##1 !(wr_en_in && addr_in == 8'h3c)
    |=> osc_calibration_word_out[7:0] == $past(wr_data_in, 2))
    else $error("cal low byte");
  chk_cal_high: assert property (!$past(srst_in)
    |-> osc_calibration_word_out[15:8] == $past(osc_calibration_high_in))
    else $error("cal high byte");
  chk_unused_zero: assert property (!(addr_in inside {[8'h3b:8'h3c]}) |=> rd_data_out[7:2] == 0)
    else $error("unused bits");
  cover property (integrator_freeze_out [*2]);
  cover property (pecl_enable_out);
  cover property (lvds_enable_out);
endmodule : pocr_chk

bind pocr_regs pocr_chk pocr_chk_i (.*);

/* testbench.sv */
// Self-checking bench for the output, loop and calibration register bank
`timescale 1ns/100ps
//----------
// Bench
//----------
module testbench;
  import pocr_pkg::*;
  logic ref_clk_in = 0, srst_in = 1, wr_en_in = 0, loop_locked_in = 0, fz = 0;
  logic at_min_limit_in = 0, at_max_limit_in = 0, pecl_enable_out, lvds_enable_out;
  logic diff_driver_enable_out, use_acquisition_bw_out, integrator_freeze_out;
  logic [7:0] addr_in = 0, wr_data_in = 0, osc_calibration_high_in = 0, rd_data_out;
  logic [15:0] loop_freq_in = 0, reported_freq_out, osc_calibration_word_out, rep = 0;
  logic [7:0] m [3] = '{8'h02, 8'h88, 8'h99};
  logic [7:0] k [3] = '{8'h03, 8'h88, 8'hff};
  int err_total = 0, compares = 0;
  pocr_regs pocr_regs_i (.*);
  initial forever #10 ref_clk_in = ~ref_clk_in;
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : cyc
  task automatic chk(logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr_in = a;
    wr_data_in = d;
    wr_en_in = 1;
    cyc(1);
    wr_en_in = 0;
    if (a inside {[8'h3a:8'h3c]}) m[a - 8'h3a] = d & k[a - 8'h3a];
  endtask : wr
  task automatic rd(logic [7:0] a);
    addr_in = a;
    cyc(2);
    chk(rd_data_out, a inside {[8'h3a:8'h3c]} ? m[a - 8'h3a] : 8'h00);
  endtask : rd
  task automatic give_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    #20000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    logic [31:0] r;
    logic [7:0] a;
    void'($urandom(27));
    cyc(4);
    srst_in = 0;
    for (int j = 0; j < 4; j++) rd(8'h3a + 8'(j));
    // Code field of the first register walks all four codes
    for (int i = 0; i < 32; i++)
    begin
      r = $urandom;
      a = 8'h3a + 8'(i % 4);
      wr(a, a == 8'h3a ? {r[7:2], 2'(i / 4)} : r[7:0]);
      if (!fz) rep = loop_freq_in;
      {loop_locked_in, at_min_limit_in, at_max_limit_in} = r[10:8];
      loop_freq_in = r[31:16];
      osc_calibration_high_in = r[15:8];
      fz = m[1][3] && (r[9] || r[8]);
      if (!fz) rep = loop_freq_in;
      cyc(2);
      chk(pecl_enable_out, m[0][1:0] == STD_PECL);
      chk(diff_driver_enable_out, m[0][1:0] inside {STD_PECL, STD_LVDS});
      chk(lvds_enable_out, m[0][1:0] == STD_LVDS);
      chk(use_acquisition_bw_out, m[1][7] && !loop_locked_in);
      chk(integrator_freeze_out, fz);
      chk(reported_freq_out, rep);
      chk(osc_calibration_word_out, {osc_calibration_high_in, m[2]});
      rd(a);
    end
    give_verdict();
  end
endmodule : testbench
